//--- logic/baud_tick.sv
`timescale 1ns/1ps

module baud_tick
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// rate
	input  wire logic [DIV_W-1:0] divisor,
	// oversample enable
	output logic                  tick
);

	typedef struct packed {
		logic [DIV_W-1:0] count;
	} tick_state_t;

	tick_state_t cur;
	tick_state_t next_cur;

	// reload also when the divisor shrinks below the count
	always_comb begin
		next_cur = cur;
		if (cur.count == '0 || cur.count >= divisor) begin
			next_cur.count = divisor - DIV_W'(1);
		end else begin
			next_cur.count = cur.count - DIV_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign tick = (cur.count == '0);

endmodule

//--- logic/modem_serial_port.sv
// Overview of operation
// - idle line mark, start bit is space
// - seven character bits, lsb first
// - parity bit then stop bit, odd/even
// - parity unchecked when disabled, still sent
// - mark means one, space means zero
// - any idle gap, fixed bit period inside
// - selectable rates, ten bit frame
// - no transmit start while clear-to-send off
// - receive only while carrier detect on
`timescale 1ns/1ps

module modem_serial_port
	import serial_port_pkg::*;
#(
	parameter int unsigned DIV_300 = DIV_300_DEFAULT
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// modem lines
	output logic                   txd,
	input  wire logic              rxd,
	input  wire logic              cts,
	input  wire logic              dcd
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ctrl_t             ctrl;
		logic              frame_err;
		logic              par_err;
		logic              overrun;
		logic [1:0]        cts_s;
		logic [1:0]        dcd_s;
		logic [1:0]        rxd_s;
		tx_state_t         tx_st;
		logic [3:0]        tx_ph;
		logic [2:0]        tx_cnt;
		logic [CHAR_W-1:0] tx_sh;
		logic              tx_par;
		logic              txd;
		rx_state_t         rx_st;
		logic [3:0]        rx_ph;
		logic [2:0]        rx_cnt;
		logic [CHAR_W-1:0] rx_sh;
		logic              rx_par;
		logic [31:0]       prdata;
	} state_t;

	localparam state_t ST_RESET = '{
		ctrl: CTRL_RESET, frame_err: 1'b0, par_err: 1'b0, overrun: 1'b0,
		cts_s: 2'h0, dcd_s: 2'h0, rxd_s: {MARK, MARK},
		tx_st: TX_IDLE, tx_ph: 4'h0, tx_cnt: 3'h0, tx_sh: '0,
		tx_par: 1'b0, txd: MARK,
		rx_st: RX_IDLE, rx_ph: 4'h0, rx_cnt: 3'h0, rx_sh: '0,
		rx_par: 1'b0, prdata: 32'h0000_0000};

	state_t cur;
	state_t next_cur;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		unique case (a)
			OFF_CTRL:   s = SEL_CTRL;
			OFF_STATUS: s = SEL_STATUS;
			OFF_TXDATA: s = SEL_TXDATA;
			OFF_RXDATA: s = SEL_RXDATA;
			default:    s = SEL_NONE;
		endcase
		return s;
	endfunction

	function automatic logic [DIV_W-1:0] rate_div(input baud_sel_t b);
		logic [DIV_W-1:0] d;
		unique case (b)
			BAUD_300:  d = DIV_W'(DIV_300);
			BAUD_1200: d = DIV_1200;
			BAUD_1800: d = DIV_1800;
			BAUD_4800: d = DIV_4800;
		endcase
		return d;
	endfunction

	reg_sel_t sel;
	logic     access;
	logic     setup;
	logic     done;

	assign sel    = decode(paddr);
	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign done   = access && pready;

	// ----------------------------------------------------------------
	// buffers and timing
	// ----------------------------------------------------------------
	logic              tick;
	logic              tx_in_valid;
	logic              tx_in_ready;
	logic              tx_out_valid;
	logic              tx_out_ready;
	logic [CHAR_W-1:0] tx_out_data;
	logic              rx_in_valid;
	logic              rx_in_ready;
	rx_word_t          rx_in_data;
	logic              rx_out_valid;
	logic              rx_out_ready;
	rx_word_t          rx_out_data;

	baud_tick u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.divisor (rate_div(cur.ctrl.baud)),
		.tick    (tick)
	);

	// a full transmit buffer holds the bus in its access phase
	assign tx_in_valid  = access && pwrite && (sel == SEL_TXDATA);
	// pop only a word that setup reported valid, or a late arrival is lost
	assign rx_out_ready = done && !pwrite && (sel == SEL_RXDATA) &&
		cur.prdata[RX_VALID_BIT];

	pair_buffer #(.W(CHAR_W)) u_tx_buf (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (tx_in_valid),
		.in_ready  (tx_in_ready),
		.in_data   (pwdata[CHAR_W-1:0]),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready),
		.out_data  (tx_out_data)
	);

	pair_buffer #(.W($bits(rx_word_t))) u_rx_buf (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_in_data),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  (rx_out_data)
	);

	assign pready  = (pwrite && sel == SEL_TXDATA) ? tx_in_ready : 1'b1;
	assign pslverr = access && (sel == SEL_NONE);

	// ----------------------------------------------------------------
	// status view
	// ----------------------------------------------------------------
	status_t status;
	logic    cts_on;
	logic    dcd_on;
	logic    rx_line;

	assign cts_on  = cur.cts_s[1];
	assign dcd_on  = cur.dcd_s[1];
	assign rx_line = cur.rxd_s[1];

	always_comb begin
		status           = '0;
		status.tx_busy   = (cur.tx_st != TX_IDLE) || tx_out_valid;
		status.tx_space  = tx_in_ready;
		status.rx_avail  = rx_out_valid;
		status.frame_err = cur.frame_err;
		status.par_err   = cur.par_err;
		status.overrun   = cur.overrun;
		status.cts       = cts_on;
		status.carrier   = dcd_on;
	end

	// transmitter pops a character only on a tick, clear to send
	assign tx_out_ready = (cur.tx_st == TX_IDLE) && tick &&
		cur.ctrl.tx_en && cts_on;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic    rx_stop_seen;
	logic    rx_bad_par;
	status_t clr;

	always_comb begin
		next_cur     = cur;
		rx_in_valid  = 1'b0;
		rx_in_data   = '0;
		rx_stop_seen = 1'b0;
		rx_bad_par   = 1'b0;
		clr          = '0;

		// second flop alone feeds logic
		next_cur.cts_s = {cur.cts_s[0], cts};
		next_cur.dcd_s = {cur.dcd_s[0], dcd};
		next_cur.rxd_s = {cur.rxd_s[0], rxd};

		// read data registered during setup, held through access
		if (setup) begin
			unique case (sel)
				SEL_CTRL:   next_cur.prdata = 32'(cur.ctrl);
				SEL_STATUS: next_cur.prdata = 32'(status);
				SEL_RXDATA: begin
					next_cur.prdata = 32'(rx_out_data);
					next_cur.prdata[RX_VALID_BIT] = rx_out_valid;
				end
				default:    next_cur.prdata = '0;
			endcase
		end

		if (done && pwrite) begin
			if (sel == SEL_CTRL) begin
				next_cur.ctrl = ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
			end
			if (sel == SEL_STATUS) begin
				clr = status_t'(pwdata[$bits(status_t)-1:0]);
			end
		end

		// transmitter
		unique case (cur.tx_st)
			TX_IDLE: begin
				next_cur.txd = MARK;
				if (tx_out_ready && tx_out_valid) begin
					next_cur.tx_sh  = tx_out_data;
					next_cur.tx_par = (^tx_out_data) ^ cur.ctrl.par_odd;
					next_cur.txd    = SPACE;
					next_cur.tx_ph  = 4'h0;
					next_cur.tx_st  = TX_START;
				end
			end
			default: begin
				if (tick) begin
					next_cur.tx_ph = cur.tx_ph + 4'h1;
				end
				if (tick && cur.tx_ph == PH_LAST) begin
					unique case (cur.tx_st)
						TX_START: begin
							next_cur.txd    = cur.tx_sh[0];
							next_cur.tx_cnt = 3'h0;
							next_cur.tx_st  = TX_DATA;
						end
						TX_DATA: begin
							if (cur.tx_cnt == LAST_BIT) begin
								next_cur.txd   = cur.tx_par;
								next_cur.tx_st = TX_PARITY;
							end else begin
								next_cur.txd    = cur.tx_sh[1];
								next_cur.tx_sh  = cur.tx_sh >> 1;
								next_cur.tx_cnt = cur.tx_cnt + 3'h1;
							end
						end
						TX_PARITY: begin
							next_cur.txd   = MARK;
							next_cur.tx_st = TX_STOP;
						end
						TX_STOP: begin
							next_cur.tx_st = TX_IDLE;
						end
						default: begin
							next_cur.tx_st = TX_IDLE;
						end
					endcase
				end
			end
		endcase

		// receiver; carrier loss drops a half-received character
		if (!dcd_on || !cur.ctrl.rx_en) begin
			next_cur.rx_st = RX_IDLE;
		end else if (tick) begin
			next_cur.rx_ph = cur.rx_ph + 4'h1;
			unique case (cur.rx_st)
				RX_IDLE: begin
					next_cur.rx_ph = 4'h0;
					if (rx_line == SPACE) begin
						next_cur.rx_st = RX_START;
					end
				end
				RX_START: begin
					if (cur.rx_ph == PH_MID) begin
						next_cur.rx_ph  = 4'h0;
						next_cur.rx_cnt = 3'h0;
						next_cur.rx_st  = (rx_line == SPACE) ?
							RX_DATA : RX_IDLE;
					end
				end
				RX_DATA: begin
					if (cur.rx_ph == PH_LAST) begin
						next_cur.rx_sh  = {rx_line, cur.rx_sh[CHAR_W-1:1]};
						next_cur.rx_cnt = cur.rx_cnt + 3'h1;
						if (cur.rx_cnt == LAST_BIT) begin
							next_cur.rx_st = RX_PARITY;
						end
					end
				end
				RX_PARITY: begin
					if (cur.rx_ph == PH_LAST) begin
						next_cur.rx_par = rx_line;
						next_cur.rx_st  = RX_STOP;
					end
				end
				RX_STOP: begin
					if (cur.rx_ph == PH_LAST) begin
						rx_stop_seen   = 1'b1;
						next_cur.rx_st = RX_IDLE;
					end
				end
				default: begin
					next_cur.rx_st = RX_IDLE;
				end
			endcase
		end

		// a character lands in the buffer at its stop sample
		if (rx_stop_seen) begin
			rx_bad_par = cur.ctrl.par_en &&
				((^cur.rx_sh) ^ cur.ctrl.par_odd) != cur.rx_par;
			rx_in_valid          = 1'b1;
			rx_in_data.ch        = cur.rx_sh;
			rx_in_data.par_err   = rx_bad_par;
			rx_in_data.frame_err = (rx_line != MARK);
		end

		// sticky flags; a set in the clearing cycle wins
		next_cur.frame_err = (cur.frame_err && !clr.frame_err) ||
			rx_in_data.frame_err;
		next_cur.par_err = (cur.par_err && !clr.par_err) ||
			rx_in_data.par_err;
		next_cur.overrun = (cur.overrun && !clr.overrun) ||
			(rx_in_valid && !rx_in_ready);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= ST_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign txd    = cur.txd;
	assign prdata = cur.prdata;

endmodule

//--- logic/pair_buffer.sv
`timescale 1ns/1ps

module pair_buffer #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	typedef struct packed {
		logic [W-1:0] head;
		logic [W-1:0] spare;
		logic [1:0]   count;
	} buf_state_t;

	buf_state_t cur;
	buf_state_t next_cur;
	logic       push;
	logic       pop;

	assign in_ready  = (cur.count != 2'h2);
	assign out_valid = (cur.count != 2'h0);
	assign out_data  = cur.head;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// head moves only on a pop or a push into an empty buffer, so a reader sees a stable word
	always_comb begin
		next_cur = cur;
		if (push && pop) begin
			if (cur.count == 2'h1) begin
				next_cur.head = in_data;
			end else begin
				next_cur.head  = cur.spare;
				next_cur.spare = in_data;
			end
		end else if (pop) begin
			next_cur.head  = cur.spare;
			next_cur.count = cur.count - 2'h1;
		end else if (push) begin
			if (cur.count == 2'h0) begin
				next_cur.head = in_data;
			end else begin
				next_cur.spare = in_data;
			end
			next_cur.count = cur.count + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

//--- logic/serial_port_pkg.sv
package serial_port_pkg;

	// ----------------------------------------------------------------
	// clock and bit timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned RATE_300   = 300;
	localparam int unsigned RATE_1200  = 1200;
	localparam int unsigned RATE_1800  = 1800;
	localparam int unsigned RATE_4800  = 4800;
	localparam int unsigned DIV_W      = 16;

	// clocks per oversample tick, rounded to nearest
	localparam int unsigned DIV_300_DEFAULT =
		(CLK_HZ + RATE_300 * OVERSAMPLE / 2) / (RATE_300 * OVERSAMPLE);
	localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'(
		(CLK_HZ + RATE_1200 * OVERSAMPLE / 2) / (RATE_1200 * OVERSAMPLE));
	localparam logic [DIV_W-1:0] DIV_1800 = DIV_W'(
		(CLK_HZ + RATE_1800 * OVERSAMPLE / 2) / (RATE_1800 * OVERSAMPLE));
	localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(
		(CLK_HZ + RATE_4800 * OVERSAMPLE / 2) / (RATE_4800 * OVERSAMPLE));

	// ticks within one bit period, bits within one character
	localparam logic [3:0] PH_LAST  = 4'hF;
	localparam logic [3:0] PH_MID   = 4'h7;
	localparam int         CHAR_W   = 7;
	localparam logic [2:0] LAST_BIT = 3'h6;

	// line levels
	localparam logic MARK  = 1'b1;
	localparam logic SPACE = 1'b0;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W      = 12;
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_TXDATA = 12'h008;
	localparam logic [11:0] OFF_RXDATA = 12'h00C;
	localparam int          RX_VALID_BIT = 31;

	typedef enum logic [1:0] {
		BAUD_300  = 2'b00,
		BAUD_1200 = 2'b01,
		BAUD_1800 = 2'b10,
		BAUD_4800 = 2'b11
	} baud_sel_t;

	// field layout follows declaration order, msb first
	typedef struct packed {
		logic      rx_en;
		logic      tx_en;
		logic      par_odd;
		logic      par_en;
		baud_sel_t baud;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{rx_en: 1'b0, tx_en: 1'b0,
		par_odd: 1'b0, par_en: 1'b0, baud: BAUD_300};

	typedef struct packed {
		logic carrier;
		logic cts;
		logic overrun;
		logic par_err;
		logic frame_err;
		logic rx_avail;
		logic tx_space;
		logic tx_busy;
	} status_t;

	typedef struct packed {
		logic              par_err;
		logic              frame_err;
		logic [CHAR_W-1:0] ch;
	} rx_word_t;

	typedef enum logic [2:0] {
		SEL_CTRL   = 3'b000,
		SEL_STATUS = 3'b001,
		SEL_TXDATA = 3'b010,
		SEL_RXDATA = 3'b011,
		SEL_NONE   = 3'b100
	} reg_sel_t;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_START  = 3'b001,
		TX_DATA   = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP   = 3'b100
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_START  = 3'b001,
		RX_DATA   = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP   = 3'b100
	} rx_state_t;

endpackage

//--- sim/modem_model.sv
`timescale 1ns/1ps

module modem_model #(
	parameter int BIT = 64
) (
	// clock
	input  wire logic pclk,
	// line
	input  wire logic txd,
	output logic      rxd,
	output logic      cts,
	output logic      dcd
);
	logic [8:0] got[$];
	logic [9:0] fr;

	initial begin
		rxd = 1'h1;
		cts = 1'h1;
		dcd = 1'h1;
	end

	// ------------------------------------------
	// sender, explicit parity and stop levels
	// ------------------------------------------
	task automatic send(input logic [6:0] ch, input logic par,
		input logic stp);
		logic [9:0] f = {stp, par, ch, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			rxd <= f[i];
			repeat (BIT - 1) @(posedge pclk);
		end
		@(posedge pclk);
		rxd <= 1'h1;
	endtask

	// ------------------------------------------
	// receiver, samples bit centres
	// ------------------------------------------
	initial forever begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			fr = {txd, fr[9:1]};
			if (i < 9)
				repeat (BIT) @(posedge pclk);
		end
		got.push_back(fr[9:1]);
	end
endmodule

//--- sim/modem_serial_port_asserts.sv
`timescale 1ns/1ps

module port_checker
	import serial_port_pkg::*;
#(
	parameter int unsigned DIV_300 = DIV_300_DEFAULT
) (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// modem lines
	input wire logic              txd,
	input wire logic              rxd,
	input wire logic              cts,
	input wire logic              dcd
);
	// ------------------------------------------
	// frame tracker, follows rate from bus writes
	// ------------------------------------------
	logic [1:0] baud;
	logic       odd;
	logic [6:0] bits;
	logic       mapped;
	int         len;
	int         fcnt;

	assign mapped = paddr inside {OFF_CTRL, OFF_STATUS, OFF_TXDATA, OFF_RXDATA};
	always_comb begin
		case (baud)
			2'h0: len = 16 * DIV_300;
			2'h1: len = 16 * DIV_1200;
			2'h2: len = 16 * DIV_1800;
			default: len = 16 * DIV_4800;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud <= 2'h0;
			odd <= 1'h0;
			bits <= 7'h00;
			fcnt <= 0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
				baud <= pwdata[1:0];
				odd <= pwdata[3];
			end
			if (fcnt != 0)
				fcnt <= (fcnt == 10 * len - 1) ? 0 : fcnt + 1;
			else if (!txd)
				fcnt <= 1;
			if (fcnt % len == len / 2)
				bits <= {txd, bits[6:1]};
		end
	end

	// ------------------------------------------
	// properties
	// ------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_reset_mark;
		$rose(presetn) |-> txd;
	endproperty
	a_reset_mark: assert property (p_reset_mark)
		else $error("line not mark after reset");
	property p_start_space;
		fcnt > 0 && fcnt < len |-> !txd;
	endproperty
	a_start_space: assert property (p_start_space)
		else $error("start bit not held at space");
	property p_parity;
		fcnt == 8 * len + len / 2 |-> txd == (^bits ^ odd);
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity bit wrong");
	property p_stop_mark;
		fcnt >= 9 * len |-> txd;
	endproperty
	a_stop_mark: assert property (p_stop_mark)
		else $error("stop bit not mark");
	property p_bit_edges;
		fcnt != 0 && $changed(txd) |-> fcnt % len == 0;
	endproperty
	a_bit_edges: assert property (p_bit_edges)
		else $error("line changed inside a bit");
	property p_cts_gate;
		fcnt == 0 && !txd |-> $past(cts, 2) || $past(cts, 3) || $past(cts, 4);
	endproperty
	a_cts_gate: assert property (p_cts_gate)
		else $error("start while clear to send off");
	property p_unmapped;
		psel && penable && !mapped |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_err_only;
		pslverr |-> psel && penable && !mapped;
	endproperty
	a_err_only: assert property (p_err_only)
		else $error("spurious slave error");
endmodule

bind modem_serial_port port_checker #(.DIV_300(DIV_300)) port_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd), .cts(cts),
	.dcd(dcd));

//--- sim/modem_serial_port_tb.sv
`timescale 1ns/1ps

module modem_serial_port_tb;
	import serial_port_pkg::*;
	localparam int DIV   = 4;
	localparam int BIT   = 16 * DIV;
	localparam int FRAME = 10 * BIT;

	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic              pready;
	logic              pslverr;
	logic              serr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic [31:0]       rd;
	logic              txd;
	logic              rxd;
	logic              cts;
	logic              dcd;
	int                err_count;
	int                checks_done;

	modem_serial_port #(.DIV_300(DIV)) modem_serial_port_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
		.cts(cts), .dcd(dcd));
	modem_model #(.BIT(BIT)) modem_model_i (
		.pclk(pclk), .txd(txd), .rxd(rxd), .cts(cts), .dcd(dcd));

	always #12.5 pclk = ~pclk;

	// ------------------------------------------
	// shared tasks
	// ------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 5000);
		rd = prdata;
		serr = pslverr;
		chk("pready", 1, {31'h0, pready});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wait_idle;
		int n = 0;
		do begin
			apb(0, OFF_STATUS, 0);
			n++;
		end while (rd[0] !== 1'h0 && n < 2000);
	endtask

	task automatic chk_frame(input logic [6:0] c, input logic odd);
		logic [8:0] f = 9'h000;
		if (modem_model_i.got.size() > 0)
			f = modem_model_i.got.pop_front();
		chk("frame", {23'h0, 1'h1, ^c ^ odd, c}, {23'h0, f});
	endtask

	task automatic rx(input logic [6:0] c, input logic p, input logic s,
		input logic [31:0] e);
		modem_model_i.send(c, p, s);
		apb(0, OFF_RXDATA, 0);
		chk("rxdata", e, rd);
	endtask

	// ------------------------------------------
	// scenarios
	// ------------------------------------------
	task automatic t_regs;
		apb(0, OFF_CTRL, 0);
		chk("ctrl reset", 0, rd);
		for (int b = 0; b < 4; b++) begin
			apb(1, OFF_CTRL, 32'h3C | b);
			apb(0, OFF_CTRL, 0);
			chk("ctrl", 32'h3C | b, rd);
		end
		apb(0, 12'h010, 0);
		chk("unmapped", 32'h1, {rd[30:0], serr});
	endtask

	task automatic t_tx;
		logic [6:0] c[3] = '{7'h4B, 7'h00, 7'h7F};
		apb(1, OFF_CTRL, 32'h10);
		foreach (c[i]) apb(1, OFF_TXDATA, {25'h0, c[i]});
		wait_idle;
		foreach (c[i]) chk_frame(c[i], 0);
		apb(1, OFF_CTRL, 32'h18);
		apb(1, OFF_TXDATA, 32'h4B);
		wait_idle;
		chk_frame(7'h4B, 1);
	endtask

	task automatic t_cts;
		modem_model_i.cts <= 1'h0;
		repeat (4) @(posedge pclk);
		apb(1, OFF_TXDATA, 32'h55);
		repeat (2 * FRAME) @(posedge pclk);
		chk("held", 0, modem_model_i.got.size());
		modem_model_i.cts <= 1'h1;
		wait_idle;
		chk_frame(7'h55, 1);
	endtask

	task automatic t_rx;
		apb(1, OFF_CTRL, 32'h24);
		rx(7'h4B, 0, 1, 32'h8000004B);
		rx(7'h4B, 1, 1, 32'h8000014B);
		apb(1, OFF_CTRL, 32'h20);
		rx(7'h4B, 1, 1, 32'h8000004B);
		rx(7'h31, 1, 0, 32'h800000B1);
		apb(0, OFF_RXDATA, 0);
		chk("rx empty", 0, {31'h0, rd[31]});
		apb(0, OFF_STATUS, 0);
		chk("status err", 32'h18, rd & 32'h38);
		apb(1, OFF_STATUS, 32'h38);
		apb(0, OFF_STATUS, 0);
		chk("status clr", 0, rd & 32'h38);
		// let a false start on the broken stop bit die out
		repeat (BIT) @(posedge pclk);
		modem_model_i.send(7'h11, 0, 1);
		modem_model_i.send(7'h22, 0, 1);
		rx(7'h33, 0, 1, 32'h80000011);
		apb(0, OFF_RXDATA, 0);
		chk("rx second", 32'h80000022, rd);
		apb(0, OFF_STATUS, 0);
		chk("overrun", 32'h20, rd & 32'h38);
		modem_model_i.dcd <= 1'h0;
		repeat (4) @(posedge pclk);
		modem_model_i.send(7'h4B, 0, 1);
		apb(0, OFF_RXDATA, 0);
		chk("rx no carrier", 0, {31'h0, rd[31]});
	endtask

	// ------------------------------------------
	// run control
	// ------------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge pclk);
		err_count++;
		print_verdict;
	end

	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = '0;
		pwdata = '0;
		err_count = 0;
		checks_done = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_tx;
		t_cts;
		t_rx;
		print_verdict;
	end
endmodule
